// ### odc_spi_ctrl.sv
// Pin configuration, channel drive and SPI slave of an eight-channel driver.
// Assumes an SPI master on spi_clk/cs_n/sdi, raw asynchronous pins, and
// analog fault/level/slow flags arriving asynchronously to ref_clk.
`timescale 1ns/1ps
`include "odc_cfg.svh"

module odc_spi_ctrl #(
	parameter int unsigned WD_CYCLES    = `ODC_WD_CYCLES,
	parameter int unsigned FILT_CYCLES  = `ODC_FILT_CYCLES,
	parameter bit          FULL_VARIANT = 1'b1
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       spi_clk,
	input  wire logic       cs_n,
	input  wire logic       sdi,
	output logic            sdo_out,
	output logic            sdo_oe,
	input  wire logic       serial_setting_select,
	input  wire logic       global_push_pull_select,
	input  wire logic       global_open_load_enable,
	input  wire logic       crc_enable_pin,
	input  wire logic       glitch_filter_enable,
	input  wire logic       watchdog_enable_pin,
	input  wire logic       command_mode_select,
	input  wire logic       configuration_select,
	input  wire logic       word_length_select,
	input  wire logic [7:0] chan_in,
	input  wire logic [7:0] fault_in,
	input  wire logic [7:0] level_in,
	input  wire logic [7:0] slow_in,
	output logic      [7:0] high_side_switch,
	output logic      [7:0] low_side_switch,
	output logic      [7:0] push_pull_mode,
	output logic      [7:0] open_load_active,
	output logic      [7:0] led_level,
	output logic            crc_check_enable,
	output logic            watchdog_active,
	output logic            watchdog_fault_n,
	output logic      [7:0] command_byte,
	output logic      [7:0] command_data,
	output logic            command_strobe
);

	// ----------------------------------------------------------------
	// Link domain (spi_clk)
	// ----------------------------------------------------------------
	logic [15:0]           rx_sh_reg;
	logic [7:0]            rx_cnt_reg;
	logic                  frame_act_reg;
	logic [15:0]           tx_sh_reg;
	logic                  tx_ld_reg;
	logic [15:0]           tx_word_reg;
	odc_pkg::odc_frame_mode_t mode_reg;
	logic                  tx_bit;
	// Sample on rising edge; counter restarts at each frame's first edge
	always_ff @(posedge spi_clk or negedge reset_n) begin
		if (!reset_n)
			rx_sh_reg <= `ODC_RST_WORD;
		else
			rx_sh_reg <= {rx_sh_reg[14:0], sdi};
	end
	always_ff @(posedge spi_clk or posedge cs_n or negedge reset_n) begin
		if (!reset_n)
			frame_act_reg <= 1'b0;
		else if (cs_n)
			frame_act_reg <= 1'b0;
		else
			frame_act_reg <= 1'b1;
	end
	// Count survives chip-select rise so the core can judge the frame
	always_ff @(posedge spi_clk or negedge reset_n) begin
		if (!reset_n)
			rx_cnt_reg <= `ODC_RST_BYTE;
		else if (!frame_act_reg)
			rx_cnt_reg <= 8'h01;
		else if (rx_cnt_reg != `ODC_CNT_MAX)
			rx_cnt_reg <= rx_cnt_reg + 8'h01;
	end
	always_ff @(negedge spi_clk or posedge cs_n or negedge reset_n) begin
		if (!reset_n)
			tx_ld_reg <= 1'b0;
		else if (cs_n)
			tx_ld_reg <= 1'b0;
		else
			tx_ld_reg <= 1'b1;
	end

	// Snapshot loads on first falling edge, then received bits follow it out
	always_ff @(negedge spi_clk or negedge reset_n) begin
		if (!reset_n)
			tx_sh_reg <= `ODC_RST_WORD;
		else if (!tx_ld_reg)
			tx_sh_reg <= {tx_word_reg[14:0], rx_sh_reg[0]};
		else
			tx_sh_reg <= {tx_sh_reg[14:0], rx_sh_reg[0]};
	end

	// tx_word_reg and mode_reg are held steady by the core for the whole frame
	always_comb begin
		if (mode_reg == odc_pkg::ODC_FRAME_DIR8)
			tx_bit = tx_ld_reg ? tx_sh_reg[7] : tx_word_reg[7];
		else
			tx_bit = tx_ld_reg ? tx_sh_reg[15] : tx_word_reg[15];
	end

	assign sdo_oe  = !cs_n;
	assign sdo_out = !cs_n && tx_bit;
	// ----------------------------------------------------------------
	// Pin synchronisers and glitch filters (ref_clk)
	// ----------------------------------------------------------------
	logic [`ODC_PIN_W-1:0] pin_raw;
	logic [`ODC_PIN_W-1:0] pin_s1_reg;
	logic [`ODC_PIN_W-1:0] pin_s2_reg;
	logic [`ODC_PIN_W-1:0] pin_flt_reg;
	logic [`ODC_PIN_W-1:0] pin_f;
	logic [23:0]           ana_s1_reg;
	logic [23:0]           ana_s2_reg;
	logic                  cs_s1_reg;
	logic                  cs_s2_reg;
	logic                  cs_s3_reg;
	localparam logic [`ODC_PIN_W-1:0] FORCE_FILT = `ODC_FORCE_FILT;
	assign pin_raw = {word_length_select, configuration_select, command_mode_select,
		watchdog_enable_pin, glitch_filter_enable, crc_enable_pin, global_open_load_enable,
		global_push_pull_select, serial_setting_select, chan_in};
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			ana_s1_reg <= '0;
			ana_s2_reg <= '0;
			cs_s1_reg  <= 1'b1;
			cs_s2_reg  <= 1'b1;
			cs_s3_reg  <= 1'b1;
		end else begin
			pin_s1_reg <= pin_raw;
			pin_s2_reg <= pin_s1_reg;
			ana_s1_reg <= {slow_in, level_in, fault_in};
			ana_s2_reg <= ana_s1_reg;
			cs_s1_reg  <= cs_n;
			cs_s2_reg  <= cs_s1_reg;
			cs_s3_reg  <= cs_s2_reg;
		end
	end

	// A level must hold FILT_CYCLES clocks to pass; adds that much latency
	genvar gi;
	generate
		for (gi = 0; gi < `ODC_PIN_W; gi++) begin : g_filt
			logic [7:0] cnt_reg;
			always_ff @(posedge ref_clk or negedge reset_n) begin
				if (!reset_n) begin
					cnt_reg         <= `ODC_RST_BYTE;
					pin_flt_reg[gi] <= 1'b0;
				end else if (pin_s2_reg[gi] == pin_flt_reg[gi]) begin
					cnt_reg <= `ODC_RST_BYTE;
				end else if (cnt_reg >= 8'(FILT_CYCLES - 1)) begin
					cnt_reg         <= `ODC_RST_BYTE;
					pin_flt_reg[gi] <= pin_s2_reg[gi];
				end else begin
					cnt_reg <= cnt_reg + 8'h01;
				end
			end
			assign pin_f[gi] = (FORCE_FILT[gi] || pin_flt_reg[`ODC_IDX_FLT])
				? pin_flt_reg[gi] : pin_s2_reg[gi];
		end
	endgenerate

	logic       ser_f;
	logic       pp_f;
	logic       ol_f;
	logic       cfg_f;
	logic [7:0] chan_f;
	logic [7:0] fault_s;
	logic [7:0] level_s;
	logic [7:0] slow_s;
	logic       cs_fall;
	logic       cs_rise;
	assign ser_f   = pin_f[`ODC_IDX_SER];
	assign pp_f    = pin_f[`ODC_IDX_PP];
	assign ol_f    = pin_f[`ODC_IDX_OL];
	assign cfg_f   = pin_f[`ODC_IDX_CFG];
	assign chan_f  = pin_f[7:0];
	assign fault_s = ana_s2_reg[7:0];
	assign level_s = ana_s2_reg[15:8];
	assign slow_s  = ana_s2_reg[23:16];
	assign cs_fall = cs_s3_reg && !cs_s2_reg;
	assign cs_rise = !cs_s3_reg && cs_s2_reg;

	// ----------------------------------------------------------------
	// Frame start: mode and status snapshot
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg    <= odc_pkg::ODC_FRAME_CMD;
			tx_word_reg <= `ODC_RST_WORD;
		end else if (cs_fall) begin
			if (pin_f[`ODC_IDX_CMD] || !ser_f) begin
				mode_reg    <= odc_pkg::ODC_FRAME_CMD;
				tx_word_reg <= {fault_s, cfg_f ? slow_s : level_s};
			end else if (pin_f[`ODC_IDX_S16]) begin
				mode_reg    <= odc_pkg::ODC_FRAME_DIR16;
				tx_word_reg <= {fault_s, cfg_f ? slow_s : level_s};
			end else begin
				mode_reg    <= odc_pkg::ODC_FRAME_DIR8;
				tx_word_reg <= {`ODC_RST_BYTE, fault_s};
			end
		end
	end

	// ----------------------------------------------------------------
	// Frame end: apply a complete word
	// ----------------------------------------------------------------
	logic       word_ok;
	logic [7:0] out_set_reg;
	logic [7:0] pp_cfg_reg;
	logic [7:0] ol_en_reg;
	assign word_ok = (mode_reg == odc_pkg::ODC_FRAME_DIR8) ? (rx_cnt_reg >= `ODC_LEN_SHORT)
		: (rx_cnt_reg >= `ODC_LEN_LONG);
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_set_reg <= `ODC_RST_BYTE;
			pp_cfg_reg  <= `ODC_RST_BYTE;
			ol_en_reg   <= `ODC_RST_BYTE;
		end else if (cs_rise && word_ok) begin
			unique case (mode_reg)
				odc_pkg::ODC_FRAME_DIR8: begin
					if (cfg_f)
						pp_cfg_reg <= rx_sh_reg[7:0];
					else
						out_set_reg <= rx_sh_reg[7:0];
				end
				odc_pkg::ODC_FRAME_DIR16: begin
					if (!cfg_f) begin
						out_set_reg <= rx_sh_reg[15:8];
						pp_cfg_reg  <= rx_sh_reg[7:0];
					end else begin
						for (int i = 0; i < `ODC_CHANNELS; i++) begin
							if ({rx_sh_reg[i+8], rx_sh_reg[i]} == `ODC_CODE_HS_GLOB) begin
								pp_cfg_reg[i] <= 1'b0;
								ol_en_reg[i]  <= 1'b0;
							end else if ({rx_sh_reg[i+8], rx_sh_reg[i]} == `ODC_CODE_PP) begin
								pp_cfg_reg[i] <= 1'b1;
							end else if ({rx_sh_reg[i+8], rx_sh_reg[i]} == `ODC_CODE_HS_OL) begin
								pp_cfg_reg[i] <= 1'b0;
								ol_en_reg[i]  <= 1'b1;
							end
						end
					end
				end
				odc_pkg::ODC_FRAME_CMD: begin
				end
			endcase
		end
	end

	// Register map decode lives outside; the command is handed on as received
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			command_byte   <= `ODC_RST_BYTE;
			command_data   <= `ODC_RST_BYTE;
			command_strobe <= 1'b0;
		end else begin
			command_strobe <= cs_rise && word_ok && mode_reg == odc_pkg::ODC_FRAME_CMD;
			if (cs_rise && word_ok && mode_reg == odc_pkg::ODC_FRAME_CMD) begin
				command_byte <= rx_sh_reg[15:8];
				command_data <= rx_sh_reg[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Watchdog on chip-select activity
	// ----------------------------------------------------------------
	logic        wd_en;
	logic [31:0] wd_cnt_reg;
	logic        wd_trip_reg;
	assign wd_en = ser_f && pin_f[`ODC_IDX_WD];
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wd_cnt_reg  <= '0;
			wd_trip_reg <= 1'b0;
		end else if (cs_fall || !wd_en) begin
			wd_cnt_reg  <= '0;
			wd_trip_reg <= 1'b0;
		end else if (wd_cnt_reg >= WD_CYCLES - 1) begin
			wd_trip_reg <= 1'b1;
		end else begin
			wd_cnt_reg <= wd_cnt_reg + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// Channel drive and configuration outputs
	// ----------------------------------------------------------------
	logic [7:0] pp_eff;
	logic [7:0] lvl_eff;
	logic [7:0] ol_eff;
	always_comb begin
		if (pp_f)
			pp_eff = 8'hFF;
		else if (ser_f || FULL_VARIANT)
			pp_eff = pp_cfg_reg;
		else
			pp_eff = `ODC_RST_BYTE;
		lvl_eff = ser_f ? out_set_reg : chan_f;
		if (ser_f)
			ol_eff = ~pp_eff & (ol_en_reg | {8{ol_f}});
		else if (FULL_VARIANT)
			ol_eff = ~pp_eff & ol_en_reg;
		else
			ol_eff = ~pp_eff;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			high_side_switch <= `ODC_RST_BYTE;
			low_side_switch  <= `ODC_RST_BYTE;
			push_pull_mode   <= `ODC_RST_BYTE;
			open_load_active <= `ODC_RST_BYTE;
			led_level        <= `ODC_RST_BYTE;
			crc_check_enable <= 1'b0;
			watchdog_active  <= 1'b0;
			watchdog_fault_n <= 1'b1;
		end else begin
			high_side_switch <= wd_trip_reg ? `ODC_RST_BYTE : lvl_eff;
			low_side_switch  <= wd_trip_reg ? `ODC_RST_BYTE : (pp_eff & ~lvl_eff);
			push_pull_mode   <= pp_eff;
			open_load_active <= ol_eff;
			led_level        <= ~fault_s & ((ser_f && cfg_f) ? slow_s : level_s);
			crc_check_enable <= ser_f && pin_f[`ODC_IDX_CRC];
			watchdog_active  <= wd_en;
			watchdog_fault_n <= !wd_trip_reg;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);
	a_pp_global: assert property (pp_f |=> push_pull_mode == 8'hFF)
		else $error("push-pull pin did not force all channels");
	a_ol_global: assert property (ser_f && ol_f |=> (open_load_active | push_pull_mode) == 8'hFF)
		else $error("global open-load not applied");
	a_crc_gate: assert property (!ser_f |=> !crc_check_enable)
		else $error("crc enabled in parallel mode");
	a_wd_idle: assert property (!wd_en |=> wd_cnt_reg == 32'h0 ##1 watchdog_fault_n)
		else $error("watchdog ran while disabled");
	a_par_follow: assert property (!ser_f && !wd_trip_reg |=> high_side_switch == $past(chan_f))
		else $error("parallel outputs do not follow pins");
	a_red_ol: assert property (!FULL_VARIANT && !ser_f |=> (open_load_active | push_pull_mode) == 8'hFF)
		else $error("reduced variant open-load off");
	a_apply_edge: assert property (!$stable(out_set_reg) |-> $past(cs_rise))
		else $error("output setting changed outside frame end");
	a_snap_edge: assert property (!$stable(tx_word_reg) |-> $past(cs_fall))
		else $error("status snapshot changed mid frame");
	a_short_frame: assert property (cs_rise && !word_ok |=> $stable(out_set_reg) && $stable(pp_cfg_reg))
		else $error("short frame was applied");
	a_led_slow: assert property (ser_f && cfg_f |=> led_level == ($past(slow_s) & ~$past(fault_s)))
		else $error("leds not showing slow mode");
	c_dir8: cover property (cs_rise && word_ok && mode_reg == odc_pkg::ODC_FRAME_DIR8);
	c_dir16: cover property (cs_rise && word_ok && mode_reg == odc_pkg::ODC_FRAME_DIR16);
	c_cmd: cover property (command_strobe);
	c_wd_trip: cover property (!watchdog_fault_n);

endmodule // odc_spi_ctrl

// ### odc_cfg.svh
// Constants of the octal driver configuration and SPI control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ODC_CFG_SVH
`define ODC_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define ODC_CLK_MHZ        200
`define ODC_WD_TIMEOUT_MS  900
`define ODC_WD_CYCLES      (`ODC_WD_TIMEOUT_MS * `ODC_CLK_MHZ * 1000)
`define ODC_FILT_CYCLES    4

// ----------------------------------------------------------------
// Widths and frame lengths
// ----------------------------------------------------------------
`define ODC_CHANNELS       8
`define ODC_LEN_SHORT      8'h08
`define ODC_LEN_LONG       8'h10
`define ODC_CNT_MAX        8'hFF

// ----------------------------------------------------------------
// Pin vector layout after synchronisation
// ----------------------------------------------------------------
`define ODC_PIN_W          17
`define ODC_IDX_SER        8
`define ODC_IDX_PP         9
`define ODC_IDX_OL         10
`define ODC_IDX_CRC        11
`define ODC_IDX_FLT        12
`define ODC_IDX_WD         13
`define ODC_IDX_CMD        14
`define ODC_IDX_CFG        15
`define ODC_IDX_S16        16
// Pins filtered whatever the filter pin says
`define ODC_FORCE_FILT     17'h01300

// ----------------------------------------------------------------
// Reset values and two-bit mode codes
// ----------------------------------------------------------------
`define ODC_RST_BYTE       8'h00
`define ODC_RST_WORD       16'h0000
`define ODC_CODE_HS_GLOB   2'h0
`define ODC_CODE_PP        2'h1
`define ODC_CODE_HS_OL     2'h2

`endif

// ### odc_pkg.sv
// Types of the octal driver configuration and SPI control block.
// Assumes odc_cfg.svh is on the include path.
`include "odc_cfg.svh"

package odc_pkg;
	// Kind of SPI frame, fixed at the chip-select falling edge
	typedef enum logic [2:0] {
		ODC_FRAME_DIR8  = 3'b001,
		ODC_FRAME_DIR16 = 3'b010,
		ODC_FRAME_CMD   = 3'b100
	} odc_frame_mode_t;
endpackage

// ### odc_spi_master.sv
// SPI master model that stands on the far side of the driver's serial port.
// Assumes a free-running link clock and the resolved serial-out wire as input.
`timescale 1ns/1ps

module odc_spi_master (
	input  wire logic lclk,
	input  wire logic sdo,
	output logic      spi_clk,
	output logic      cs_n,
	output logic      sdi
);
	initial begin
		spi_clk = 1'b0;
		cs_n    = 1'b1;
		sdi     = 1'b0;
	end

	// ----------------------------------------------------------------
	// Frame task
	// ----------------------------------------------------------------
	// MSB first; data changes with the falling edge, sampled on the rising one
	task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0000_0000;
		@(posedge lclk) cs_n <= 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			@(negedge lclk) begin
				spi_clk <= 1'b0;
				sdi     <= tx[i];
			end
			@(posedge lclk) begin
				spi_clk <= 1'b1;
				rx = {rx[30:0], sdo};
			end
		end
		@(negedge lclk) spi_clk <= 1'b0;
		@(posedge lclk) begin
			cs_n <= 1'b1;
			sdi  <= ~sdi;
		end
		// Gap with select high, clock parked low
		repeat (2) @(posedge lclk);
	endtask
endmodule // odc_spi_master

// ### tb_top.sv
// Self-checking bench for the octal driver configuration and SPI block.
// Assumes odc_spi_master.sv and the design files are compiled first.
`timescale 1ns/1ps

module tb_top;
	logic        ref_clk;
	logic        lclk;
	logic        reset_n;
	logic [8:0]  pin_reg;
	logic [7:0]  chan_reg;
	logic [7:0]  fault_reg;
	logic [7:0]  level_reg;
	logic [7:0]  slow_reg;
	logic        spi_clk;
	logic        cs_n;
	logic        sdi;
	logic        sdo_out;
	logic        sdo_oe;
	logic [7:0]  hs;
	logic [7:0]  ls;
	logic [7:0]  pp;
	logic [7:0]  ol;
	logic [7:0]  led;
	logic [7:0]  cmd_b;
	logic [7:0]  cmd_d;
	logic        crc_en;
	logic        wd_act;
	logic        wd_flt_n;
	logic        cmd_stb;
	logic [31:0] rx;
	int          strobes;
	int          s0;
	int          miscompares;
	int          compares;
	// Weak pull-down on the released serial output
	wire         sdo_w = sdo_oe ? sdo_out : 1'b0;

	// ----------------------------------------------------------------
	// Clocks and instances
	// ----------------------------------------------------------------
	always #2.5 ref_clk = ~ref_clk;
	initial begin
		lclk = 1'b0;
		#13;
		forever #40 lclk = ~lclk;
	end
	always @(posedge ref_clk) if (cmd_stb === 1'b1) strobes++;

	odc_spi_master m (.lclk(lclk), .sdo(sdo_w), .spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi));

	odc_spi_ctrl #(.WD_CYCLES(1000), .FILT_CYCLES(4), .FULL_VARIANT(1'b1)) DUT (
		.ref_clk(ref_clk), .reset_n(reset_n), .spi_clk(spi_clk), .cs_n(cs_n), .sdi(sdi),
		.sdo_out(sdo_out), .sdo_oe(sdo_oe), .serial_setting_select(pin_reg[8]),
		.global_push_pull_select(pin_reg[7]), .global_open_load_enable(pin_reg[6]),
		.crc_enable_pin(pin_reg[5]), .glitch_filter_enable(pin_reg[4]), .watchdog_enable_pin(pin_reg[3]),
		.command_mode_select(pin_reg[2]), .configuration_select(pin_reg[1]), .word_length_select(pin_reg[0]),
		.chan_in(chan_reg), .fault_in(fault_reg), .level_in(level_reg), .slow_in(slow_reg),
		.high_side_switch(hs), .low_side_switch(ls), .push_pull_mode(pp), .open_load_active(ol),
		.led_level(led), .crc_check_enable(crc_en), .watchdog_active(wd_act), .watchdog_fault_n(wd_flt_n),
		.command_byte(cmd_b), .command_data(cmd_d), .command_strobe(cmd_stb)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Pins {ser,pp,ol,crc,flt,wd,cmd,cfg,s16}; waits out sync and filter
	task automatic setp(input logic [8:0] p);
		@(posedge ref_clk) pin_reg <= p;
		repeat (12) @(posedge ref_clk);
	endtask

	task automatic tend(input string name);
		$display("TB: test %s done", name);
	endtask

	task automatic test_done;
		$display("TB: %0d compares, %0d miscompares", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		test_done();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		reset_n = 1'b0;
		pin_reg = 9'h100;
		chan_reg = 8'hFF;
		fault_reg = 8'hA5;
		level_reg = 8'h81;
		slow_reg = 8'h66;
		strobes = 0;
		miscompares = 0;
		compares = 0;
		repeat (6) @(posedge ref_clk);
		reset_n <= 1'b1;
		setp(9'h100);
		m.xfer(8, 32'h3C, rx);
		chk(rx[7:0], 8'hA5);
		chk(hs, 8'h3C);
		chk(ls, 8'h00);
		chk(sdo_oe, 1'b0);
		chk(sdo_w, 1'b0);
		tend("dir8_level");
		setp(9'h102);
		m.xfer(8, 32'h0F, rx);
		chk(pp, 8'h0F);
		chk(hs, 8'h3C);
		chk(ls, 8'h03);
		chk(led, 8'h42);
		setp(9'h182);
		chk(pp, 8'hFF);
		chk(ls, 8'hC3);
		tend("dir8_mode");
		setp(9'h101);
		m.xfer(16, 32'hF000, rx);
		chk(rx[15:0], 16'hA581);
		chk(hs, 8'hF0);
		chk(pp, 8'h00);
		setp(9'h103);
		m.xfer(16, 32'h0C0A, rx);
		chk(rx[15:0], 16'hA566);
		chk(pp, 8'h02);
		chk(ol, 8'h04);
		chk(hs, 8'hF0);
		setp(9'h143);
		chk(ol, 8'hFD);
		tend("dir16");
		setp(9'h100);
		m.xfer(5, 32'h1F, rx);
		chk(hs, 8'hF0);
		m.xfer(16, 32'h5AC3, rx);
		chk(hs, 8'hC3);
		chk(rx[15:0], 16'hA55A);
		tend("short_and_chain");
		setp(9'h104);
		s0 = strobes;
		m.xfer(16, 32'h1234, rx);
		chk(cmd_b, 8'h12);
		chk(cmd_d, 8'h34);
		chk(16'(strobes - s0), 16'h0001);
		chk(rx[15:0], 16'hA581);
		tend("command");
		@(posedge ref_clk) chan_reg <= 8'h94;
		setp(9'h030);
		chk(hs, 8'h94);
		chk(ls, 8'h02);
		chk(crc_en, 1'b0);
		chk(wd_act, 1'b0);
		m.xfer(16, 32'hABCD, rx);
		chk(cmd_b, 8'hAB);
		chk(hs, 8'h94);
		tend("parallel");
		setp(9'h128);
		chk(crc_en, 1'b1);
		chk(wd_act, 1'b1);
		repeat (1100) @(posedge ref_clk);
		chk(wd_flt_n, 1'b0);
		chk(hs, 8'h00);
		m.xfer(8, 32'h11, rx);
		chk(wd_flt_n, 1'b1);
		chk(hs, 8'h11);
		tend("watchdog");
		test_done();
	end
endmodule // tb_top
